// ### tb/packed_fp_simd_datapath_test.sv
// Self-checking bench for the packed double-precision SIMD datapath
`timescale 1ns/1ns
module packed_fp_simd_datapath_test;
   import pfd_pkg::*;
   localparam logic [63:0] d1 = 64'h3ff0_0000_0000_0000;
   localparam logic [63:0] d2 = 64'h4000_0000_0000_0000;
   localparam logic [63:0] d3 = 64'h4008_0000_0000_0000;
   logic clk_in, reset_in, op_valid, res_v, fl_v, inval, got_v;
   logic [1:0] rmode;
   pfd_op_t op_code;
   logic [127:0] a, b, res, got;
   logic [7:0] imm, imm_d;
   logic [2:0] flags, got_fl;
   int errors, n_compared, cyc;
   pfd_datapath i_pfd_datapath (.clk_in(clk_in), .reset_in(reset_in), .op_valid_in(op_valid),
      .op_code_in(op_code), .src_a_in(a), .src_b_in(b), .imm_in(imm_d), .round_mode_in(rmode),
      .result_out(res), .result_valid_out(res_v), .status_flags_out(flags),
      .flags_valid_out(fl_v), .invalid_out(inval));
   pfd_issue_model i_pfd_issue_model (.clk_in(clk_in), .op_valid_out(op_valid),
      .op_code_out(op_code), .src_a_out(a), .src_b_out(b), .imm_out(imm_d), .result_in(res),
      .result_valid_in(res_v), .status_flags_in(flags), .got_out(got),
      .got_flags_out(got_fl), .got_valid_out(got_v));
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   task automatic chk(input logic [127:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic run(input pfd_op_t op, input logic [127:0] x, y, e);
      i_pfd_issue_model.issue(op, x, y, imm);
      chk(128'h1, {127'h0, got_v});
      chk(e, got);
   endtask
   task automatic t_logic;
      run(op_and_packed_double, {8{16'hff00}}, {8{16'hf0f0}}, {8{16'hf000}});
      run(op_and_not_packed_double, {8{16'hff00}}, {8{16'hf0f0}}, {8{16'h00f0}});
      run(op_or_packed_double, {8{16'hff00}}, {8{16'hf0f0}}, {8{16'hfff0}});
      run(op_xor_packed_double, {8{16'hff00}}, {8{16'hf0f0}}, {8{16'h0ff0}});
   endtask
   task automatic t_lanes;
      run(op_interleave_upper_lanes, {d1, d2}, {d3, d3}, {d3, d1});
      run(op_interleave_lower_lanes, {d1, d2}, {d3, d3}, {d3, d2});
      run(op_quadword_add, {64'h1, {4{16'hffff}}}, {2{64'h1}}, {64'h2, 64'h0});
      run(op_unsigned_dword_multiply, {2{32'h0, 32'hffff_ffff}}, {2{64'h2}},
         {2{64'h1_ffff_fffe}});
      imm = 8'h01;
      run(op_wide_shift_left, 128'h1, 128'h0, 128'h100);
      imm = 8'h10;
      run(op_wide_shift_right, {8{16'hffff}}, 128'h0, 128'h0);
   endtask
   task automatic t_fp;
      run(op_alternating_addsub_double, {d2, d2}, {d1, d1}, {d3, d1});
      run(op_alternating_addsub_single, {4{32'h4000_0000}}, {4{32'h3f80_0000}},
         {2{32'h4040_0000, 32'h3f80_0000}});
      run(op_horizontal_add_double, {d1, d2}, {d1, d1}, {d2, d3});
      run(op_horizontal_sub_double, {d1, d2}, {d2, d1}, {64'hbff0_0000_0000_0000, d1});
   endtask
   task automatic t_conv;
      run(op_truncating_double_to_int, {d1, 64'h4004_0000_0000_0000}, 128'h0, 128'h1_0000_0002);
      run(op_rounding_double_to_int, {d1, 64'h4004_0000_0000_0000}, 128'h0, 128'h1_0000_0003);
      run(op_stack_truncating_int_store, 128'h4004_0000_0000_0000, 128'h0, 128'h2);
   endtask
   task automatic t_flags;
      run(op_ordered_scalar_compare_flags, {d3, d1}, {d1, d2}, 128'h0);
      chk(128'h1, {125'h0, got_fl});
      run(op_ordered_scalar_compare_flags, d2, d2, 128'h0);
      chk(128'h4, {125'h0, got_fl});
      run(op_unordered_scalar_compare_flags, d1, 64'h7ff8_0000_0000_0000, 128'h0);
      chk(128'h7, {125'h0, got_fl});
   endtask
   task automatic wrap_up;
      $display("errors=%0d n_compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         wrap_up;
      end
   end
   initial
   begin
      reset_in = 1'b1;
      rmode = 2'h2;
      imm = 8'h00;
      repeat (6) @(posedge clk_in);
      #1;
      reset_in = 1'b0;
      chk(128'h0, {res[125:0], res_v, fl_v});
      t_logic;
      t_lanes;
      t_fp;
      t_conv;
      t_flags;
      wrap_up;
   end
endmodule

// ### tb/pfd_issue_model.sv
// Issue and writeback model: presents one operation, collects its result
`timescale 1ns/1ns
module pfd_issue_model
   import pfd_pkg::*;
(
   input wire logic clk_in,
   output logic op_valid_out,
   output pfd_op_t op_code_out,
   output logic [127:0] src_a_out,
   output logic [127:0] src_b_out,
   output logic [7:0] imm_out,
   input wire logic [127:0] result_in,
   input wire logic result_valid_in,
   input wire logic [2:0] status_flags_in,
   output logic [127:0] got_out,
   output logic [2:0] got_flags_out,
   output logic got_valid_out
);
   initial
   begin
      op_valid_out = 1'b0;
      op_code_out = op_quadword_add;
      src_a_out = '0;
      src_b_out = '1;
      imm_out = 8'h00;
   end
   // Code, operands and strobe go out in one cycle; taken at the next edge
   task automatic issue(input pfd_op_t op, input logic [127:0] a, b, input logic [7:0] imm);
      @(posedge clk_in);
      #1;
      op_valid_out = 1'b1;
      op_code_out = op;
      src_a_out = a;
      src_b_out = b;
      imm_out = imm;
      @(posedge clk_in);
      #1;
      op_valid_out = 1'b0;
      // Released operands do not keep their last value
      src_a_out = ~a;
      src_b_out = ~b;
      got_out = result_in;
      got_flags_out = status_flags_in;
      got_valid_out = result_valid_in;
   endtask
endmodule

// ### verilog/pfd_datapath.sv
// Packed double-precision SIMD execution datapath with one-cycle result
// Operation
// - Bitwise AND, AND-NOT, OR, XOR full width
// - Compares write lane masks or status flags
// - Ordered scalar compare sets flags from low lanes
// - Unordered scalar compare, quiet NaN not invalid
// - Interleave upper lanes of both operands
// - Interleave lower lanes of both operands
// - Truncating conversions round toward zero; other integer conversions use mode
// - Single/double conversion both ways, packed and scalar
// - Stack truncating store always truncates
// - Single addsub: add odd, subtract even pairs
// - Double addsub: add upper, subtract lower
// - Single horizontal add pairs in order
// - Single horizontal subtract pairs in order
// - Double horizontal add per operand
// - Double horizontal subtract per operand
// - Whole-register byte shifts fill zeros
// - Unsigned doubleword multiply, full products
// - Lane-wise quadword add and subtract
// - Half-register word shuffles, full doubleword shuffle
`timescale 1ns/1ns
`include "pfd_params.svh"
module pfd_datapath
   import pfd_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic op_valid_in,
   input wire pfd_op_t op_code_in,
   input wire logic [127:0] src_a_in,
   input wire logic [127:0] src_b_in,
   input wire logic [7:0] imm_in,
   input wire logic [1:0] round_mode_in,
   output logic [127:0] result_out,
   output logic result_valid_out,
   output logic [2:0] status_flags_out,
   output logic flags_valid_out,
   output logic invalid_out
);
   logic [127:0] result;
   logic result_valid;
   logic [2:0] status_flags;
   logic flags_valid;
   logic invalid;
   logic [127:0] next_result;
   logic [2:0] next_flags;
   logic next_fvalid;
   logic next_invalid;

   function automatic logic [31:0] dbl_to_sgl(input logic [63:0] d);
      logic [10:0] e;
      e = d[62:52];
      dbl_to_sgl = {d[63], 31'h0000_0000};
      if (e == 11'h07ff)
         dbl_to_sgl = {d[63], 8'hff, (d[51:0] != 52'h0), d[50:29]};
      else if (e > `PFD_SGL_MAX_EXP)
         dbl_to_sgl = {d[63], 8'hff, 23'h00_0000};
      else if (e >= `PFD_SGL_MIN_EXP)
         dbl_to_sgl = {d[63], 8'(e - `PFD_EXP_GAP), d[51:29]};
   endfunction

   function automatic logic [63:0] sgl_to_dbl(input logic [31:0] s);
      logic [7:0] e;
      e = s[30:23];
      if (e == 8'hff)
         sgl_to_dbl = {s[31], 11'h07ff, s[22] | (s[21:0] != 22'h0), s[21:0], 29'h0000_0000};
      else if (e == 8'h00)
         sgl_to_dbl = {s[31], 63'h0000_0000_0000_0000};
      else
         sgl_to_dbl = {s[31], {3'h0, e} + `PFD_EXP_GAP, s[22:0], 29'h0000_0000};
   endfunction

   // Out-of-range values give the integer indefinite pattern
   function automatic logic [63:0] dbl_to_int(input logic [63:0] d, input logic [1:0] rm,
                                              input logic wide);
      logic [10:0] e;
      logic [63:0] m;
      logic [63:0] mag;
      logic [63:0] rem;
      logic [63:0] half;
      logic [5:0] sh;
      logic inc;
      e = d[62:52];
      m = (e == 11'h000) ? 64'h0 : {11'h000, 1'b1, d[51:0]};
      mag = 64'h0;
      rem = 64'h0;
      half = 64'h0;
      sh = 6'h00;
      inc = 1'b0;
      if (e >= (wide ? `PFD_INT64_LIM : `PFD_INT32_LIM))
         return wide ? `PFD_INDEF64 : {32'h0000_0000, `PFD_INDEF32};
      if (e >= `PFD_MAN_TOP)
         mag = m << (e - `PFD_MAN_TOP);
      else
      begin
         sh = ((`PFD_MAN_TOP - e) > 11'h003f) ? 6'h3f : 6'(`PFD_MAN_TOP - e);
         mag = m >> sh;
         rem = m & ((64'h1 << sh) - 64'h1);
         half = 64'h1 << (sh - 6'h01);
      end
      case (rm)
         `PFD_RM_NEAREST: inc = (rem != 64'h0) && ((rem > half) || ((rem == half) && mag[0]));
         `PFD_RM_DOWN: inc = d[63] && (rem != 64'h0);
         `PFD_RM_UP: inc = !d[63] && (rem != 64'h0);
         default: inc = 1'b0;
      endcase
      mag = mag + {63'h0, inc};
      mag = d[63] ? -mag : mag;
      dbl_to_int = wide ? mag : {32'h0000_0000, mag[31:0]};
   endfunction

   function automatic logic [63:0] shuf_words(input logic [63:0] v, input logic [7:0] c);
      for (int i = 0; i < 4; i++)
         shuf_words[16*i +: 16] = v[16*c[2*i +: 2] +: 16];
   endfunction

   function automatic logic [127:0] shuf_dwords(input logic [127:0] v, input logic [7:0] c);
      for (int i = 0; i < 4; i++)
         shuf_dwords[32*i +: 32] = v[32*c[2*i +: 2] +: 32];
   endfunction

   function automatic logic cmp_pred(input logic [2:0] p, input logic lt, input logic eq,
                                     input logic un);
      case (p)
         `PFD_PRED_EQ: cmp_pred = eq;
         `PFD_PRED_LT: cmp_pred = lt;
         `PFD_PRED_LE: cmp_pred = lt | eq;
         `PFD_PRED_UNORD: cmp_pred = un;
         `PFD_PRED_NEQ: cmp_pred = !eq;
         `PFD_PRED_NLT: cmp_pred = !lt;
         `PFD_PRED_NLE: cmp_pred = !(lt | eq);
         default: cmp_pred = !un;
      endcase
   endfunction

   function automatic logic [2:0] cmp_flags(input logic lt, input logic eq, input logic un);
      cmp_flags = `PFD_FLAGS_RESET;
      cmp_flags[`PFD_FLAG_ZF] = un | eq;
      cmp_flags[`PFD_FLAG_PF] = un;
      cmp_flags[`PFD_FLAG_CF] = un | lt;
   endfunction

   // Lane comparators
   logic [1:0] lt, eq, un, sn, cmp_bit;
   for (genvar g = 0; g < 2; g++)
   begin : g_cmp
      pfd_fcmp u_cmp (
         .x_in(src_a_in[64*g +: 64]),
         .y_in(src_b_in[64*g +: 64]),
         .lt_out(lt[g]),
         .eq_out(eq[g]),
         .unord_out(un[g]),
         .snan_out(sn[g])
      );
      assign cmp_bit[g] = cmp_pred(imm_in[2:0], lt[g], eq[g], un[g]);
   end
   // Ordering predicates fault on any NaN, the others only on signalling NaN
   wire logic pred_signals = imm_in[0] ^ imm_in[1];

   // Adder lane steering
   wire logic [255:0] ab = {src_b_in, src_a_in};
   wire logic h_single = (op_code_in == op_horizontal_add_single) ||
      (op_code_in == op_horizontal_sub_single);
   wire logic h_double = (op_code_in == op_horizontal_add_double) ||
      (op_code_in == op_horizontal_sub_double);
   logic [31:0] sx [4];
   logic [31:0] sy [4];
   logic [31:0] ssum [4];
   logic ssub [4];
   logic [63:0] dx [2];
   logic [63:0] dy [2];
   logic [63:0] dsum [2];
   logic dsub [2];

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         sx[i] = h_single ? ab[64*i +: 32] : src_a_in[32*i +: 32];
         sy[i] = h_single ? ab[64*i+32 +: 32] : src_b_in[32*i +: 32];
         ssub[i] = h_single ? (op_code_in == op_horizontal_sub_single) : (i % 2 == 0);
      end
      for (int i = 0; i < 2; i++)
      begin
         dx[i] = h_double ? ab[128*i +: 64] : src_a_in[64*i +: 64];
         dy[i] = h_double ? ab[128*i+64 +: 64] : src_b_in[64*i +: 64];
         dsub[i] = h_double ? (op_code_in == op_horizontal_sub_double) : (i == 0);
      end
   end

   for (genvar g = 0; g < 4; g++)
   begin : g_single
      pfd_fadd #(.EXP_W(8), .MAN_W(23)) u_add (
         .x_in(sx[g]),
         .y_in(sy[g]),
         .sub_in(ssub[g]),
         .sum_out(ssum[g])
      );
   end
   for (genvar g = 0; g < 2; g++)
   begin : g_double
      pfd_fadd #(.EXP_W(11), .MAN_W(52)) u_add (
         .x_in(dx[g]),
         .y_in(dy[g]),
         .sub_in(dsub[g]),
         .sum_out(dsum[g])
      );
   end

   // Integer conversion: truncating forms force round toward zero
   wire logic cvt_trunc = (op_code_in == op_truncating_double_to_int) ||
      (op_code_in == op_truncating_double_to_int_narrow) ||
      (op_code_in == op_stack_truncating_int_store);
   wire logic cvt_wide = (op_code_in == op_stack_truncating_int_store) ||
      (op_code_in == op_stack_int_store_pop);
   wire logic [1:0] cvt_mode = cvt_trunc ? `PFD_RM_ZERO : round_mode_in;
   wire logic [63:0] int0 = dbl_to_int(src_a_in[63:0], cvt_mode, cvt_wide);
   wire logic [63:0] int1 = dbl_to_int(src_a_in[127:64], cvt_mode, 1'b0);

   wire logic [127:0] shl_res = (imm_in > `PFD_MAX_SHIFT_BYTES) ? 128'h0 :
      src_a_in << {imm_in[3:0], 3'b000};
   wire logic [127:0] shr_res = (imm_in > `PFD_MAX_SHIFT_BYTES) ? 128'h0 :
      src_a_in >> {imm_in[3:0], 3'b000};
   wire logic [127:0] mul_res = {64'(src_a_in[95:64]) * 64'(src_b_in[95:64]),
      64'(src_a_in[31:0]) * 64'(src_b_in[31:0])};

   always_comb
   begin
      next_result = 128'h0;
      next_flags = `PFD_FLAGS_RESET;
      next_fvalid = 1'b0;
      next_invalid = 1'b0;
      case (op_code_in)
         op_and_packed_double: next_result = src_a_in & src_b_in;
         op_and_not_packed_double: next_result = ~src_a_in & src_b_in;
         op_or_packed_double: next_result = src_a_in | src_b_in;
         op_xor_packed_double: next_result = src_a_in ^ src_b_in;
         op_compare_packed_double:
         begin
            next_result = {{64{cmp_bit[1]}}, {64{cmp_bit[0]}}};
            next_invalid = pred_signals ? |un : |sn;
         end
         op_compare_scalar_double:
         begin
            next_result = {src_a_in[127:64], {64{cmp_bit[0]}}};
            next_invalid = pred_signals ? un[0] : sn[0];
         end
         op_ordered_scalar_compare_flags:
         begin
            next_flags = cmp_flags(lt[0], eq[0], un[0]);
            next_fvalid = 1'b1;
            next_invalid = un[0];
         end
         op_unordered_scalar_compare_flags:
         begin
            next_flags = cmp_flags(lt[0], eq[0], un[0]);
            next_fvalid = 1'b1;
            next_invalid = sn[0];
         end
         op_interleave_upper_lanes: next_result = {src_b_in[127:64], src_a_in[127:64]};
         op_interleave_lower_lanes: next_result = {src_b_in[63:0], src_a_in[63:0]};
         op_truncating_double_to_int,
         op_truncating_double_to_int_narrow,
         op_rounding_double_to_int: next_result = {64'h0, int1[31:0], int0[31:0]};
         op_stack_truncating_int_store,
         op_stack_int_store_pop: next_result = {64'h0, int0};
         op_packed_single_to_double:
            next_result = {sgl_to_dbl(src_a_in[63:32]), sgl_to_dbl(src_a_in[31:0])};
         op_packed_double_to_single:
            next_result = {64'h0, dbl_to_sgl(src_a_in[127:64]),
               dbl_to_sgl(src_a_in[63:0])};
         op_scalar_single_to_double:
            next_result = {src_a_in[127:64], sgl_to_dbl(src_b_in[31:0])};
         op_scalar_double_to_single:
            next_result = {src_a_in[127:32], dbl_to_sgl(src_b_in[63:0])};
         op_alternating_addsub_single,
         op_horizontal_add_single,
         op_horizontal_sub_single: next_result = {ssum[3], ssum[2], ssum[1], ssum[0]};
         op_alternating_addsub_double,
         op_horizontal_add_double,
         op_horizontal_sub_double: next_result = {dsum[1], dsum[0]};
         op_wide_shift_left: next_result = shl_res;
         op_wide_shift_right: next_result = shr_res;
         op_unsigned_dword_multiply: next_result = mul_res;
         op_quadword_add: next_result = {src_a_in[127:64] + src_b_in[127:64],
            src_a_in[63:0] + src_b_in[63:0]};
         op_quadword_subtract: next_result = {src_a_in[127:64] - src_b_in[127:64],
            src_a_in[63:0] - src_b_in[63:0]};
         op_low_half_word_shuffle:
            next_result = {src_a_in[127:64], shuf_words(src_a_in[63:0], imm_in)};
         op_high_half_word_shuffle:
            next_result = {shuf_words(src_a_in[127:64], imm_in), src_a_in[63:0]};
         op_doubleword_shuffle: next_result = shuf_dwords(src_a_in, imm_in);
         default: next_result = 128'h0;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         result <= 128'h0;
         result_valid <= 1'b0;
         status_flags <= `PFD_FLAGS_RESET;
         flags_valid <= 1'b0;
         invalid <= 1'b0;
      end
      else
      begin
         result_valid <= op_valid_in;
         flags_valid <= op_valid_in & next_fvalid;
         invalid <= op_valid_in & next_invalid;
         if (op_valid_in)
            result <= next_result;
         if (op_valid_in && next_fvalid)
            status_flags <= next_flags;
      end
   end

   assign result_out = result;
   assign result_valid_out = result_valid;
   assign status_flags_out = status_flags;
   assign flags_valid_out = flags_valid;
   assign invalid_out = invalid;

   // Operand copies used only by the checks below
   logic [127:0] a_q;
   logic [127:0] b_q;
   always_ff @(posedge clk_in)
   begin
      a_q <= src_a_in;
      b_q <= src_b_in;
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   property p_and;
      op_valid_in && op_code_in == op_and_packed_double |=>
         result_out == (a_q & b_q) && result_valid_out;
   endproperty
   a_and: assert property (p_and) else $error("and result wrong");

   property p_and_not;
      op_valid_in && op_code_in == op_and_not_packed_double |=> result_out == (~a_q & b_q);
   endproperty
   a_and_not: assert property (p_and_not) else $error("and-not result wrong");

   property p_ordered_eq;
      op_valid_in && op_code_in == op_ordered_scalar_compare_flags &&
         src_a_in[63:0] == src_b_in[63:0] && src_a_in[62:52] != 11'h7ff |=>
         flags_valid_out && status_flags_out == `PFD_FLAGS_EQ && !invalid_out;
   endproperty
   a_ordered_eq: assert property (p_ordered_eq) else $error("ordered flags wrong");

   property p_unordered_quiet;
      op_valid_in && op_code_in == op_unordered_scalar_compare_flags &&
         src_b_in[62:51] == 12'hfff && !sn[0] |=>
         status_flags_out == `PFD_FLAGS_UNORD && !invalid_out;
   endproperty
   a_unordered_quiet: assert property (p_unordered_quiet) else $error("unordered wrong");

   property p_upper;
      op_valid_in && op_code_in == op_interleave_upper_lanes |=>
         result_out == {b_q[127:64], a_q[127:64]};
   endproperty
   a_upper: assert property (p_upper) else $error("upper interleave wrong");

   property p_lower;
      op_valid_in && op_code_in == op_interleave_lower_lanes |=>
         result_out == {b_q[63:0], a_q[63:0]};
   endproperty
   a_lower: assert property (p_lower) else $error("lower interleave wrong");

   property p_shift;
      op_valid_in && op_code_in == op_wide_shift_left && imm_in == 8'h01 |=>
         result_out == {a_q[119:0], 8'h00};
   endproperty
   a_shift: assert property (p_shift) else $error("byte shift wrong");

   property p_multiply;
      op_valid_in && op_code_in == op_unsigned_dword_multiply |=>
         result_out[127:64] == 64'(a_q[95:64]) * 64'(b_q[95:64]);
   endproperty
   a_multiply: assert property (p_multiply) else $error("multiply wrong");

   property p_quad_add;
      op_valid_in && op_code_in == op_quadword_add |=>
         result_out[63:0] == a_q[63:0] + b_q[63:0];
   endproperty
   a_quad_add: assert property (p_quad_add) else $error("quadword add wrong");

   property p_valid;
      1'b1 |=> result_valid_out == $past(op_valid_in);
   endproperty
   a_valid: assert property (p_valid) else $error("result valid timing wrong");

   property p_reset;
      disable iff (1'b0) reset_in |=> !result_valid_out && !flags_valid_out;
   endproperty
   a_reset: assert property (p_reset) else $error("valid after reset");
endmodule

// ### verilog/pfd_fadd.sv
// Floating-point adder/subtractor, round to nearest even, denormals flushed
`timescale 1ns/1ns
module pfd_fadd
#(
   parameter int EXP_W = 11,
   parameter int MAN_W = 52
)
(
   input wire logic [EXP_W+MAN_W:0] x_in,
   input wire logic [EXP_W+MAN_W:0] y_in,
   input wire logic sub_in,
   output logic [EXP_W+MAN_W:0] sum_out
);
   localparam int W = 1 + EXP_W + MAN_W;
   localparam int L = MAN_W + 4;
   localparam logic [EXP_W-1:0] EMAX = '1;

   if (EXP_W < 2 || MAN_W < 4)
   begin : g_bad
      $error("pfd_fadd: exponent or mantissa too narrow");
   end

   logic sx, sy, sb, ss, swap, nan_x, nan_y, inf_x, inf_y;
   logic [EXP_W-1:0] ex, ey, eb, es;
   logic [MAN_W-1:0] mx, my;
   logic [L-1:0] fb, fs, al;
   logic [L:0] sum;
   logic [MAN_W:0] rm;
   int d, e;

   always_comb
   begin
      sx = x_in[W-1];
      sy = y_in[W-1] ^ sub_in;
      ex = x_in[W-2 -: EXP_W];
      ey = y_in[W-2 -: EXP_W];
      mx = x_in[MAN_W-1:0];
      my = y_in[MAN_W-1:0];
      nan_x = (ex == EMAX) && (mx != '0);
      nan_y = (ey == EMAX) && (my != '0);
      inf_x = (ex == EMAX) && (mx == '0);
      inf_y = (ey == EMAX) && (my == '0);
      // Larger magnitude goes first so the difference never goes negative
      swap = {ey, my} > {ex, mx};
      sb = swap ? sy : sx;
      ss = swap ? sx : sy;
      eb = swap ? ey : ex;
      es = swap ? ex : ey;
      fb = (eb == '0) ? '0 : {1'b1, (swap ? my : mx), 3'b000};
      fs = (es == '0) ? '0 : {1'b1, (swap ? mx : my), 3'b000};
      d = int'(eb) - int'(es);
      if (d >= L)
         al = {{(L-1){1'b0}}, |fs};
      else
      begin
         al = fs >> d;
         al[0] = al[0] | (|(fs & ~({L{1'b1}} << d)));
      end
      sum = (sb == ss) ? ({1'b0, fb} + {1'b0, al}) : ({1'b0, fb} - {1'b0, al});
      e = int'(eb);
      if (sum[L])
      begin
         sum = {1'b0, sum[L:2], sum[1] | sum[0]};
         e = e + 1;
      end
      else
      begin
         for (int i = 0; i < L; i++)
         begin
            if (!sum[L-1] && (sum != '0) && (e > 1))
            begin
               sum = sum << 1;
               e = e - 1;
            end
         end
      end
      rm = {1'b0, sum[L-2:3]} + (sum[2] & (sum[1] | sum[0] | sum[3]));
      if (rm[MAN_W])
         e = e + 1;
      sum_out = {sb, EXP_W'(e), rm[MAN_W-1:0]};
      if (nan_x || nan_y || (inf_x && inf_y && (sx != sy)))
         sum_out = {1'b0, EMAX, 1'b1, {(MAN_W-1){1'b0}}};
      else if (inf_x || inf_y)
         sum_out = {(inf_x ? sx : sy), EMAX, {MAN_W{1'b0}}};
      else if (sum == '0)
         sum_out = {sx & sy, {(W-1){1'b0}}};
      else if (e >= int'(EMAX))
         sum_out = {sb, EMAX, {MAN_W{1'b0}}};
      else if (!sum[L-1])
         sum_out = {sb, {(W-1){1'b0}}};
   end
endmodule

// ### verilog/pfd_fcmp.sv
// Double-precision comparator giving less, equal, unordered and signalling flags
`timescale 1ns/1ns
module pfd_fcmp
(
   input wire logic [63:0] x_in,
   input wire logic [63:0] y_in,
   output logic lt_out,
   output logic eq_out,
   output logic unord_out,
   output logic snan_out
);
   wire logic nan_x = (&x_in[62:52]) && (|x_in[51:0]);
   wire logic nan_y = (&y_in[62:52]) && (|y_in[51:0]);
   wire logic zeros = (x_in[62:0] == 63'h0) && (y_in[62:0] == 63'h0);
   wire logic mag_lt = x_in[62:0] < y_in[62:0];
   wire logic mag_gt = x_in[62:0] > y_in[62:0];
   wire logic sign_lt = (x_in[63] && !y_in[63]) || (!x_in[63] && !y_in[63] && mag_lt)
      || (x_in[63] && y_in[63] && mag_gt);

   assign unord_out = nan_x || nan_y;
   // Quiet bit clear marks a signalling NaN
   assign snan_out = (nan_x && !x_in[51]) || (nan_y && !y_in[51]);
   assign eq_out = !unord_out && (zeros || (x_in == y_in));
   assign lt_out = !unord_out && !zeros && sign_lt;
endmodule

// ### verilog/pfd_params.svh
// Constants for the packed double-precision SIMD datapath
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH
`define PFD_RM_NEAREST 2'h0
`define PFD_RM_DOWN 2'h1
`define PFD_RM_UP 2'h2
`define PFD_RM_ZERO 2'h3
`define PFD_FLAG_CF 0
`define PFD_FLAG_PF 1
`define PFD_FLAG_ZF 2
`define PFD_FLAGS_RESET 3'h0
`define PFD_FLAGS_EQ 3'h4
`define PFD_FLAGS_UNORD 3'h7
`define PFD_PRED_EQ 3'h0
`define PFD_PRED_LT 3'h1
`define PFD_PRED_LE 3'h2
`define PFD_PRED_UNORD 3'h3
`define PFD_PRED_NEQ 3'h4
`define PFD_PRED_NLT 3'h5
`define PFD_PRED_NLE 3'h6
`define PFD_INDEF32 32'h8000_0000
`define PFD_INDEF64 64'h8000_0000_0000_0000
`define PFD_EXP_GAP 11'h0380
`define PFD_SGL_MAX_EXP 11'h047e
`define PFD_SGL_MIN_EXP 11'h0381
`define PFD_INT32_LIM 11'h041e
`define PFD_INT64_LIM 11'h043e
`define PFD_MAN_TOP 11'h0433
`define PFD_MAX_SHIFT_BYTES 8'h0f
`endif

// ### verilog/pfd_pkg.sv
// Operation codes of the packed double-precision SIMD datapath
package pfd_pkg;
   typedef enum logic [5:0] {
      op_and_packed_double,
      op_and_not_packed_double,
      op_or_packed_double,
      op_xor_packed_double,
      op_compare_packed_double,
      op_compare_scalar_double,
      op_ordered_scalar_compare_flags,
      op_unordered_scalar_compare_flags,
      op_interleave_upper_lanes,
      op_interleave_lower_lanes,
      op_truncating_double_to_int,
      op_truncating_double_to_int_narrow,
      op_rounding_double_to_int,
      op_packed_single_to_double,
      op_packed_double_to_single,
      op_scalar_single_to_double,
      op_scalar_double_to_single,
      op_stack_truncating_int_store,
      op_stack_int_store_pop,
      op_alternating_addsub_single,
      op_alternating_addsub_double,
      op_horizontal_add_single,
      op_horizontal_sub_single,
      op_horizontal_add_double,
      op_horizontal_sub_double,
      op_wide_shift_left,
      op_wide_shift_right,
      op_unsigned_dword_multiply,
      op_quadword_add,
      op_quadword_subtract,
      op_low_half_word_shuffle,
      op_high_half_word_shuffle,
      op_doubleword_shuffle
   } pfd_op_t;
endpackage
